// File: pkg/mer_map.svh
// Register offsets, field positions and reset values of the MSI and
// error reporting register bank. Definitions only; included by name.
`ifndef MER_MAP_SVH
`define MER_MAP_SVH

`define MER_OFS_MSI_CTRL 12'h0F0
`define MER_OFS_MSI_ALO 12'h0F4
`define MER_OFS_MSI_AHI 12'h0F8
`define MER_OFS_MSI_DATA 12'h0FC
`define MER_OFS_ERR_HDR 12'h100
`define MER_OFS_UE_STAT 12'h104
`define MER_OFS_UE_MASK 12'h108
`define MER_OFS_UE_SEV 12'h10C
`define MER_OFS_IRQ_STAT 12'h140
`define MER_OFS_IRQ_EN 12'h144
`define MER_OFS_IRQ_CLR 12'h148

`define MER_MSI_EN_BIT 16
`define MER_MMC_LSB 17
`define MER_MMC_MSB 19
`define MER_MME_LSB 20
`define MER_MME_MSB 22
`define MER_A64_BIT 23
`define MER_MME_MAX 3'h5
`define MER_MME_RST 3'h0
`define MER_A64_RST 1'h1

`define MER_ALO_WMASK 32'hFFFF_FFFC
`define MER_DATA_W 16
`define MER_HDR_VAL 32'h1501_0001
`define MER_NEXT_LSB 20
`define MER_NEXT_VAL 12'h150
`define MER_UE_IMPL 32'h001F_F011
`define MER_UE_MASK_RST 32'h0000_0000
`define MER_UE_SEV_RST 32'h0006_2011

`define MER_EV_FATAL 0
`define MER_EV_NONFATAL 1
`define MER_EV_MSI_SENT 2
`define MER_EV_W 3

`endif

// File: pkg/mer_pkg.sv
// Types shared by the MSI and error reporting register bank.
// Assumes the offsets and fields of mer_map.svh.
package mer_pkg;
    typedef logic [11:0] mer_addr_t;
    typedef logic [31:0] mer_word_t;
    typedef enum logic [1:0] {
        MER_ST_IDLE = 2'b00,
        MER_ST_REQ = 2'b01
    } mer_msi_state_t;
endpackage

// File: pkg/mer_msi_if.sv
// Carrier between the register bank and its MSI write generator.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface mer_msi_if;
    logic msi_en;
    logic trig;
    logic [63:0] addr;
    logic [15:0] data;
    logic sent;
    modport src (output msi_en, output trig, output addr, output data,
        input sent);
    modport gen (input msi_en, input trig, input addr, input data,
        output sent);
endinterface

// File: hw/mer_msi_gen.sv
// MSI memory write generator: one request per trigger, with triggers during a write merged into one, held until ack.
// Assumes msi_ack comes from logic on the same clock.
`timescale 1ns/100ps
module mer_msi_gen
    import mer_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hot_rst,
    input wire logic ce,
    mer_msi_if.gen mif,
    input wire logic msi_ack,
    output logic msi_req,
    output logic [63:0] msi_addr,
    output logic [15:0] msi_data
);
    mer_msi_state_t state;
    logic pend;

    // A trigger seen while a write is in flight is kept, not dropped
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= MER_ST_IDLE;
            pend <= 1'b0;
            msi_req <= 1'b0;
            msi_addr <= 64'h0;
            msi_data <= 16'h0;
            mif.sent <= 1'b0;
        end else if (ce) begin
            mif.sent <= 1'b0;
            if (hot_rst) begin
                state <= MER_ST_IDLE;
                pend <= 1'b0;
                msi_req <= 1'b0;
            end else begin
                case (state)
                    MER_ST_IDLE: begin
                        if (mif.msi_en && (mif.trig || pend)) begin
                            msi_req <= 1'b1;
                            msi_addr <= mif.addr;
                            msi_data <= mif.data;
                            pend <= 1'b0;
                            state <= MER_ST_REQ;
                        end else if (!mif.msi_en) begin
                            pend <= 1'b0;
                        end
                    end
                    MER_ST_REQ: begin
                        if (mif.trig) begin
                            pend <= 1'b1;
                        end
                        if (msi_ack) begin
                            msi_req <= 1'b0;
                            mif.sent <= 1'b1;
                            state <= MER_ST_IDLE;
                        end
                    end
                    default: begin
                        state <= MER_ST_IDLE;
                        msi_req <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // mer_msi_gen

// File: hw/mer_regs.sv
// MSI capability and error reporting register bank of the bridge.
// Assumes a same-clock register port and same-clock error event pulses;
// the legacy interrupt pins are asynchronous and are synchronised here.
`timescale 1ns/100ps
`include "mer_map.svh"
module mer_regs
    import mer_pkg::*;
#(
    parameter logic [2:0] MSI_MMC = 3'h0,
    parameter int EV_W = 21,
    parameter int PIN_W = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hot_rst,
    input wire logic ce,
    input wire mer_addr_t reg_addr,
    input wire mer_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output mer_word_t reg_rdata,
    input wire logic [EV_W-1:0] err_event,
    input wire logic [PIN_W-1:0] intx_pin,
    output logic [PIN_W-1:0] intx_out,
    output logic msi_req,
    input wire logic msi_ack,
    output logic [63:0] msi_addr,
    output logic [15:0] msi_data,
    output logic irq
);
    mer_msi_if mif();

    logic msi_en;
    logic [2:0] mme;
    logic a64;
    logic [31:0] alo;
    logic [31:0] ahi;
    logic [15:0] pay;
    logic [31:0] ue_stat;
    logic [31:0] ue_mask;
    logic [31:0] ue_sev;
    logic [`MER_EV_W-1:0] istat;
    logic [`MER_EV_W-1:0] ien;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic err_int;
    logic err_int_d;
    logic [31:0] ctrl_word;
    logic [31:0] next_rdata;
    logic [31:0] ev_vec;
    logic [31:0] ue_clr;
    logic [31:0] ue_new;
    logic [31:0] ue_wipe;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_iclr;

    assign wr_ctrl = reg_wr && (reg_addr == `MER_OFS_MSI_CTRL);
    assign wr_stat = reg_wr && (reg_addr == `MER_OFS_UE_STAT);
    assign wr_iclr = reg_wr && (reg_addr == `MER_OFS_IRQ_CLR);

    // Pin synchroniser; only pin_s2 is read by logic
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else if (ce) begin
            pin_s1 <= intx_pin;
            pin_s2 <= pin_s1;
        end
    end

    // MSI registers are not sticky: hot reset returns them to defaults
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            msi_en <= 1'b0;
            mme <= `MER_MME_RST;
            a64 <= `MER_A64_RST;
            alo <= 32'h0;
            ahi <= 32'h0;
            pay <= 16'h0;
        end else if (ce) begin
            if (hot_rst) begin
                msi_en <= 1'b0;
                mme <= `MER_MME_RST;
                a64 <= `MER_A64_RST;
                alo <= 32'h0;
                ahi <= 32'h0;
                pay <= 16'h0;
            end else if (reg_wr) begin
                if (wr_ctrl) begin
                    msi_en <= reg_wdata[`MER_MSI_EN_BIT];
                    a64 <= reg_wdata[`MER_A64_BIT];
                    // A reserved code is refused and the old grant kept
                    if (reg_wdata[`MER_MME_MSB:`MER_MME_LSB]
                            <= `MER_MME_MAX) begin
                        mme <= reg_wdata[`MER_MME_MSB:`MER_MME_LSB];
                    end
                end
                if (reg_addr == `MER_OFS_MSI_ALO) begin
                    alo <= reg_wdata & `MER_ALO_WMASK;
                end
                if (reg_addr == `MER_OFS_MSI_AHI) begin
                    ahi <= reg_wdata;
                end
                if (reg_addr == `MER_OFS_MSI_DATA) begin
                    pay <= reg_wdata[`MER_DATA_W-1:0];
                end
            end
        end
    end

    always_comb begin
        ev_vec = '0;
        ev_vec[EV_W-1:0] = err_event;
        ev_vec = ev_vec & `MER_UE_IMPL;
        ue_clr = wr_stat ? (reg_wdata & `MER_UE_IMPL) : 32'h0;
        // A new error wins over a clear in the same cycle
        ue_new = ev_vec & ~ue_stat & ~ue_mask;
        ue_wipe = ue_clr & ~ev_vec;
    end

    // Sticky error registers: only the power-on reset touches them
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ue_stat <= 32'h0;
            ue_mask <= `MER_UE_MASK_RST;
            ue_sev <= `MER_UE_SEV_RST;
        end else if (ce) begin
            ue_stat <= (ue_stat & ~ue_clr) | ev_vec;
            if (reg_wr && reg_addr == `MER_OFS_UE_MASK) begin
                ue_mask <= reg_wdata & `MER_UE_IMPL;
            end
            if (reg_wr && reg_addr == `MER_OFS_UE_SEV) begin
                ue_sev <= reg_wdata & `MER_UE_IMPL;
            end
        end
    end

    // Interrupt status; set wins over the write-one clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            istat <= '0;
            ien <= '0;
        end else if (ce) begin
            if (hot_rst) begin
                istat <= '0;
                ien <= '0;
            end else begin
                istat <= (istat & ~(wr_iclr ?
                    reg_wdata[`MER_EV_W-1:0] : {`MER_EV_W{1'b0}}))
                    | {mif.sent, |(ue_new & ~ue_sev), |(ue_new & ue_sev)};
                if (reg_wr && reg_addr == `MER_OFS_IRQ_EN) begin
                    ien <= reg_wdata[`MER_EV_W-1:0];
                end
            end
        end
    end

    // Sent status is left out of err_int so a sent MSI cannot retrigger
    assign err_int = |(istat[`MER_EV_NONFATAL:`MER_EV_FATAL]
        & ien[`MER_EV_NONFATAL:`MER_EV_FATAL]);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            err_int_d <= 1'b0;
            intx_out <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            err_int_d <= err_int;
            irq <= |(istat & ien);
            if (msi_en) begin
                intx_out <= '0;
            end else begin
                intx_out <= pin_s2 | {{(PIN_W-1){1'b0}}, err_int};
            end
        end
    end

    assign mif.msi_en = msi_en;
    assign mif.trig = err_int && !err_int_d;
    assign mif.addr = a64 ? {ahi, alo} : {32'h0, alo};
    assign mif.data = pay;

    mer_msi_gen u_gen (
        .clock(clock),
        .sys_rst(sys_rst),
        .hot_rst(hot_rst),
        .ce(ce),
        .mif(mif),
        .msi_ack(msi_ack),
        .msi_req(msi_req),
        .msi_addr(msi_addr),
        .msi_data(msi_data)
    );

    always_comb begin
        ctrl_word = 32'h0;
        ctrl_word[`MER_MSI_EN_BIT] = msi_en;
        ctrl_word[`MER_MMC_MSB:`MER_MMC_LSB] = MSI_MMC;
        ctrl_word[`MER_MME_MSB:`MER_MME_LSB] = mme;
        ctrl_word[`MER_A64_BIT] = a64;
    end

    always_comb begin
        case (reg_addr)
            `MER_OFS_MSI_CTRL: next_rdata = ctrl_word;
            `MER_OFS_MSI_ALO: next_rdata = alo;
            `MER_OFS_MSI_AHI: next_rdata = ahi;
            `MER_OFS_MSI_DATA: next_rdata = {16'h0, pay};
            `MER_OFS_ERR_HDR: next_rdata = `MER_HDR_VAL;
            `MER_OFS_UE_STAT: next_rdata = ue_stat;
            `MER_OFS_UE_MASK: next_rdata = ue_mask;
            `MER_OFS_UE_SEV: next_rdata = ue_sev;
            `MER_OFS_IRQ_STAT: next_rdata = {29'h0, istat};
            `MER_OFS_IRQ_EN: next_rdata = {29'h0, ien};
            default: next_rdata = 32'h0;
        endcase
    end

    // Read data stand for one cycle only, zero otherwise
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? next_rdata : 32'h0;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    a_msi_needs_enable: assert property (
        $rose(msi_req) |-> $past(msi_en))
        else $error("MSI request raised while MSI disabled");

    a_pins_ignored_msi: assert property (
        (ce && msi_en) |=> (intx_out == '0))
        else $error("INTx output driven in MSI mode");

    a_req_count_fixed: assert property (
        (ce && reg_rd && reg_addr == `MER_OFS_MSI_CTRL)
        |=> (reg_rdata[`MER_MMC_MSB:`MER_MMC_LSB] == MSI_MMC))
        else $error("Requested vector count not the fixed value");

    a_grant_code_legal: assert property (
        (ce && wr_ctrl && !hot_rst
        && reg_wdata[`MER_MME_MSB:`MER_MME_LSB] > `MER_MME_MAX)
        |=> (mme == $past(mme)) && (mme <= `MER_MME_MAX))
        else $error("Reserved grant code accepted");

    a_next_cap_ptr: assert property (
        (ce && reg_rd && reg_addr == `MER_OFS_ERR_HDR)
        |=> (reg_rdata[31:`MER_NEXT_LSB] == `MER_NEXT_VAL))
        else $error("Next capability pointer wrong");

    a_status_sticky: assert property (
        (ce && !wr_stat) |=> ((ue_stat & $past(ue_stat)) == $past(ue_stat)))
        else $error("Error status bit lost without a clear");

    a_hot_keeps_err: assert property (
        (ce && hot_rst && !reg_wr && err_event == '0)
        |=> (ue_stat == $past(ue_stat)) && (ue_sev == $past(ue_sev)))
        else $error("Hot reset altered sticky error state");

    a_hot_keeps_mask: assert property (
        (ce && hot_rst && !reg_wr) |=> (ue_mask == $past(ue_mask)))
        else $error("Hot reset altered the error mask");

    // Legacy mode: every synchronised pin level reaches its output
    a_legacy_pin_pass: assert property (
        (ce && !msi_en)
        |=> ((intx_out & $past(pin_s2)) == $past(pin_s2)))
        else $error("Legacy pin level lost on INTx output");

    a_legacy_err_line: assert property (
        (ce && !msi_en && err_int) |=> intx_out[0])
        else $error("Error interrupt missing on INTx line");

    a_legacy_no_msi: assert property (
        (ce && !msi_en && !msi_req) |=> !msi_req)
        else $error("MSI write started in legacy mode");

    a_hot_ends_msi: assert property (
        (ce && hot_rst) |=> (!msi_en && !msi_req))
        else $error("Hot reset left MSI mode or a request active");

    // An idle generator answers a trigger at the very next edge
    a_msi_on_trigger: assert property (
        (ce && msi_en && mif.trig && !msi_req && !hot_rst) |=> msi_req)
        else $error("MSI request missing after trigger");

    a_req_held_stable: assert property (
        (msi_req && !msi_ack && !hot_rst)
        |=> (msi_req && $stable(msi_addr) && $stable(msi_data)))
        else $error("MSI request changed before acknowledge");

    a_req_drops_ack: assert property (
        (ce && msi_req && msi_ack) |=> !msi_req)
        else $error("MSI request kept after acknowledge");

    // Sent status lands two edges after the acknowledge
    a_sent_status_set: assert property (
        (ce && msi_req && msi_ack && !hot_rst) ##1 (ce && !hot_rst)
        |=> istat[`MER_EV_MSI_SENT])
        else $error("Sent status not set after MSI write");

    a_msi_addr_32bit: assert property (
        (ce && msi_en && mif.trig && !msi_req && !hot_rst && !a64)
        |=> (msi_addr[63:32] == 32'h0))
        else $error("Upper MSI address used in 32-bit mode");

    a_grant_in_range: assert property (
        mme <= `MER_MME_MAX)
        else $error("Granted vector count holds a reserved code");

    // ue_wipe holds the bits a status write clears with no new error
    a_clear_takes_effect: assert property (
        (ce && wr_stat) |=> ((ue_stat & $past(ue_wipe)) == 32'h0))
        else $error("Error status bit survived its clear");

    // A new error sets its bit even when a clear lands in the same cycle
    a_new_error_sets: assert property (
        (ce && (ev_vec != 32'h0))
        |=> ((ue_stat & $past(ev_vec)) == $past(ev_vec)))
        else $error("Detected error did not set its status bit");

    a_reserved_err_zero: assert property (
        ((ue_stat | ue_mask | ue_sev) & ~`MER_UE_IMPL) == 32'h0)
        else $error("Reserved error register bit set");

    c_msi_sent: cover property (msi_req && msi_ack && ce);
    c_legacy_int: cover property (!msi_en && intx_out[0]);
    c_stat_clear: cover property (ce && wr_stat && (ue_stat != 32'h0));
    c_set_and_clear: cover property (ce && wr_stat && (err_event != '0));
    c_fatal_irq: cover property (ce && istat[`MER_EV_FATAL]
        && ien[`MER_EV_FATAL]);
endmodule // mer_regs

// File: verification/mer_msi_sink.sv
// Far-side model that accepts MSI memory writes from the bank.
// Assumes msi_req is held until the edge that samples msi_ack high.
`timescale 1ns/100ps
module mer_msi_sink (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic msi_req,
    output logic msi_ack
);
    logic [2:0] wait_cnt;

    // A slow host lets the request stand four cycles before taking it
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wait_cnt <= 3'h0;
            msi_ack <= 1'b0;
        end else begin
            msi_ack <= 1'b0;
            if (msi_req && !msi_ack) begin
                if (wait_cnt >= (slow ? 3'h3 : 3'h0)) begin
                    msi_ack <= 1'b1;
                    wait_cnt <= 3'h0;
                end else begin
                    wait_cnt <= wait_cnt + 3'h1;
                end
            end else begin
                wait_cnt <= 3'h0;
            end
        end
    end
endmodule // mer_msi_sink

// File: verification/mer_regs_tb.sv
// Self-checking bench for the MSI and error reporting register bank.
// Assumes the default parameters of the bank and the sink model.
`timescale 1ns/100ps
module mer_regs_tb;
    import mer_pkg::*;
    typedef struct {mer_addr_t a; mer_word_t d; mer_word_t e;} mer_row_t;
    logic clock, sys_rst, hot_rst, ce, reg_wr, reg_rd, msi_ack, msi_req;
    logic irq, slow;
    mer_addr_t reg_addr;
    mer_word_t reg_wdata, reg_rdata;
    logic [20:0] err_event;
    logic [3:0] intx_pin, intx_out;
    logic [63:0] msi_addr;
    logic [15:0] msi_data;
    int bad_count = 0;
    int compares = 0;
    // Write then read back; a granted count of 6 must leave code 5 alone
    mer_row_t rows [10] = '{
        '{12'h0F4, 32'hFFFF_FFFF, 32'hFFFF_FFFC},
        '{12'h0F8, 32'h1234_5678, 32'h1234_5678},
        '{12'h0FC, 32'hFFFF_FFFF, 32'h0000_FFFF},
        '{12'h108, 32'hFFFF_FFFF, 32'h001F_F011},
        '{12'h10C, 32'h0000_0000, 32'h0000_0000},
        '{12'h100, 32'hFFFF_FFFF, 32'h1501_0001},
        '{12'h144, 32'h0000_0003, 32'h0000_0003},
        '{12'h1F0, 32'hFFFF_FFFF, 32'h0000_0000},
        '{12'h0F0, 32'h00D0_0000, 32'h00D0_0000},
        '{12'h0F0, 32'h00E0_0000, 32'h00D0_0000}};

    mer_regs dut (.clock(clock), .sys_rst(sys_rst), .hot_rst(hot_rst),
        .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .err_event(err_event), .intx_pin(intx_pin), .intx_out(intx_out),
        .msi_req(msi_req), .msi_ack(msi_ack), .msi_addr(msi_addr),
        .msi_data(msi_data), .irq(irq));
    mer_msi_sink host (.clock(clock), .sys_rst(sys_rst), .slow(slow),
        .msi_req(msi_req), .msi_ack(msi_ack));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic stop_test();
        $display("Mismatches %0d of %0d compares", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input mer_addr_t a, input mer_word_t d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input mer_addr_t a, input mer_word_t e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    task automatic pulse(input int b, input logic hot);
        @(posedge clock);
        if (hot) hot_rst <= 1'b1;
        else err_event[b] <= 1'b1;
        @(posedge clock);
        hot_rst <= 1'b0;
        err_event <= '0;
    endtask

    task automatic wait_req(input logic v);
        int n;
        n = 0;
        while (msi_req !== v && n < 20) begin
            @(posedge clock);
            #1 n++;
        end
        if (msi_req !== v) begin
            bad_count++;
            $display("Error at %0t: MSI request wait ran out", $time);
            stop_test();
        end
    endtask

    initial begin
        {hot_rst, reg_wr, reg_rd, slow} = '0;
        {reg_addr, reg_wdata, err_event, intx_pin} = '0;
        ce = 1'b1;
        sys_rst = 1'b1;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        rd(12'h0F0, 32'h0080_0000);
        rd(12'h10C, 32'h0006_2011);
        rd(12'h104, 32'h0000_0000);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        // Legacy mode: pins pass through and no MSI write goes out
        intx_pin <= 4'h5;
        repeat (4) @(posedge clock);
        #1 chk({msi_req, intx_out}, 5'h05);
        intx_pin <= 4'h0;
        pulse(12, 1'b0);
        rd(12'h104, 32'h0000_1000);
        chk(irq, 1'b0);
        wr(12'h108, 32'h0);
        pulse(13, 1'b0);
        repeat (3) @(posedge clock);
        #1 chk({irq, intx_out[0]}, 2'b11);
        // Hot reset clears MSI state but keeps the error status
        pulse(0, 1'b1);
        rd(12'h104, 32'h0000_3000);
        rd(12'h0F4, 32'h0000_0000);
        chk(irq, 1'b0);
        wr(12'h104, 32'h0000_1000);
        rd(12'h104, 32'h0000_2000);
        wr(12'h0F4, 32'h0000_1000);
        wr(12'h0F8, 32'h0000_0001);
        wr(12'h0FC, 32'h0000_BEEF);
        wr(12'h0F0, 32'h0081_0000);
        wr(12'h144, 32'h0000_0003);
        slow <= 1'b1;
        intx_pin <= 4'hF;
        repeat (4) @(posedge clock);
        #1 chk(intx_out, 4'h0);
        pulse(14, 1'b0);
        wait_req(1'b1);
        chk(msi_addr, 64'h0000_0001_0000_1000);
        chk(msi_data, 16'hBEEF);
        wait_req(1'b0);
        rd(12'h140, 32'h0000_0006);
        wr(12'h148, 32'h0000_0007);
        rd(12'h140, 32'h0000_0000);
        // Error on bit 14 and its clear in one cycle: the set wins
        @(posedge clock);
        reg_addr <= 12'h104;
        reg_wdata <= 32'h0000_4000;
        reg_wr <= 1'b1;
        err_event[14] <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        err_event <= '0;
        rd(12'h104, 32'h0000_6000);
        // Clock enable low: an error pulse must leave no trace
        @(posedge clock);
        ce <= 1'b0;
        pulse(15, 1'b0);
        ce <= 1'b1;
        rd(12'h104, 32'h0000_6000);
        // 32-bit MSI from a fatal error, then a second one while busy
        wr(12'h10C, 32'h0001_0000);
        wr(12'h0F0, 32'h0001_0000);
        pulse(16, 1'b0);
        wait_req(1'b1);
        chk(msi_addr, 64'h0000_0000_0000_1000);
        chk(irq, 1'b1);
        wr(12'h148, 32'h0000_0001);
        pulse(17, 1'b0);
        wait_req(1'b0);
        wait_req(1'b1);
        chk(msi_data, 16'hBEEF);
        wait_req(1'b0);
        rd(12'h140, 32'h0000_0006);
        stop_test();
    end
endmodule // mer_regs_tb
